// ===== hdl/pvic_pkg.sv
// Constants, register map and state encoding of the prioritised vector interrupt controller.
// Assumes one core clock, a synchronous active-low reset and an APB master for software access.
//
// Functional notes
// - Arbitrate 44 peripheral/external sources plus 4 traps in one priority scheme.
// - Vector word read from program memory is loaded into the 24-bit program counter.
// - Primary vector table starts at program word 0x000004, alternate table at 0x000084.
// - Flags in three 16-bit registers are set by sources, cleared by software writes.
// - Three 16-bit enable registers hold one permit bit per source.
// - A flag sets on its event whatever the source's enable bit says.
// - Twelve priority registers hold all levels; the last implements only bits 7:0.
// - CPU level is four bits: bit 3 in core control, bits 2:0 in core status.
// - First control register holds trap flags; second holds external config and table select.
// - Each source takes level 1 to 7; 7 is highest, 1 lowest maskable.
// - A source at level 0 is never taken, exactly as if disabled.
// - With nesting disable set, no new source is accepted during an active service; traps still are.
// - While nesting disable is 1, software writes to the CPU level are ignored.
// - Timed disable blocks levels 6 and below for a count; bit 14 reads set meanwhile.
// - 63 vectors of 24 bits in words 0x000004 to 0x0000FE; chosen vector loads the PC.
// - Normal fetch or jump into vector space, including after rollover, raises address error.
// - Each priority field is the low three bits of a nibble; the fourth reads 0.
// - Equal levels are broken by lowest source number; 0 highest, 44 lowest.
// - Assigned level dominates natural order.
// - Source n uses vector n plus 8; source 41 and those above 44 are reserved.
// - Edge, level and change qualification stay inside the peripheral.
// - The core is interrupted only by a level strictly above the CPU level.
// - Traps use fixed levels 11 to 14, so CPU level bit 3 is set during a trap.

package pvic_pkg;

  // ==========================================================================
  // Sizes
  localparam int NUM_SRC  = 48;
  localparam int NUM_TRAP = 4;
  localparam int NUM_PRIO = 12;
  localparam int EXT_W    = 5;

  // Implemented sources: 0..44 without the reserved number 41.
  localparam logic [47:0] SRC_IMPL_MASK = 48'h1DFF_FFFF_FFFF;
  localparam int          LAST_PRIO_SRC = 45;

  // ==========================================================================
  // Register byte offsets on APB
  localparam logic [11:0] OFS_FLAGS      = 12'h000;
  localparam logic [11:0] OFS_ENABLES    = 12'h00C;
  localparam logic [11:0] OFS_PRIO       = 12'h018;
  localparam logic [11:0] OFS_CTL_TRAP   = 12'h048;
  localparam logic [11:0] OFS_CTL_EXT    = 12'h04C;
  localparam logic [11:0] OFS_CPU_LEVEL  = 12'h050;
  localparam logic [11:0] OFS_STATUS     = 12'h054;

  // ==========================================================================
  // Field positions
  localparam int NEST_DIS_BIT   = 15;
  localparam int ALT_TABLE_BIT  = 15;
  localparam int TIMED_DIS_BIT  = 14;
  localparam int TRAP_LSB       = 1;
  localparam int EXT_LSB        = 0;
  localparam int CORE_CTL_BIT   = 3;
  localparam int TRAP_ADDR_IDX  = 1;
  localparam int STAT_DEPTH_LSB = 8;

  // ==========================================================================
  // Levels, vectors and reset values
  localparam logic [3:0]  TRAP_LEVEL_BASE = 4'hB;
  localparam logic [2:0]  TIMED_MAX_LEVEL = 3'h6;
  localparam logic [5:0]  SRC_VEC_OFFSET  = 6'h08;
  localparam logic [5:0]  TRAP_VEC_BASE   = 6'h01;
  localparam logic [23:0] IVT_BASE        = 24'h000004;
  localparam logic [23:0] ALTERNATE_VECTOR_TABLE_BASE       = 24'h000084;
  localparam logic [23:0] VEC_SPACE_END   = 24'h0000FF;
  localparam logic [3:0]  RST_CPU_LEVEL   = 4'h0;

  typedef enum logic [2:0] {
    PV_IDLE  = 3'b001,
    PV_FETCH = 3'b010,
    PV_LOAD  = 3'b100
  } pvic_fsm_t;

endpackage

// ===== hdl/pvic_top.sv
// Interrupt controller core: request flags, enables, priorities, arbitration and vector fetch.
// Assumes source and trap events are one-cycle pulses already qualified by their peripherals,
// and that the core returns from a handler only while no vector fetch is in progress.
`timescale 1ns/10ps

module pvic_top #(
  parameter int NEST_DEPTH = 16,
  parameter int TIMED_DISABLE_W     = 14
) (
  // Clock and reset
  input  wire logic                          clock_i,
  input  wire logic                          rst_n_i,
  // APB slave
  input  wire logic                          psel_i,
  input  wire logic                          penable_i,
  input  wire logic                          pwrite_i,
  input  wire logic [11:0]                   paddr_i,
  input  wire logic [31:0]                   pwdata_i,
  output logic      [31:0]                   prdata_o,
  output logic                               pready_o,
  output logic                               pslverr_o,
  // Request events
  input  wire logic [pvic_pkg::NUM_SRC-1:0]  src_event_i,
  input  wire logic [pvic_pkg::NUM_TRAP-1:0] trap_event_i,
  // Core fetch watch
  input  wire logic                          fetch_valid_i,
  input  wire logic                          fetch_normal_i,
  input  wire logic [23:0]                   fetch_addr_i,
  input  wire logic                          jump_valid_i,
  input  wire logic [23:0]                   jump_target_i,
  // Core timed disable and handler return
  input  wire logic                          timed_start_i,
  input  wire logic [TIMED_DISABLE_W-1:0]             timed_count_i,
  input  wire logic                          instr_retire_i,
  input  wire logic                          return_i,
  // Vector fetch from program memory
  input  wire logic                          vec_data_valid_i,
  input  wire logic [23:0]                   vec_data_i,
  output logic                               irq_o,
  output logic                               vec_rd_o,
  output logic      [23:0]                   vec_addr_o,
  output logic                               pc_load_o,
  output logic      [23:0]                   pc_value_o,
  // Status toward the core and peripherals
  output logic      [3:0]                    cpu_level_o,
  output logic      [pvic_pkg::EXT_W-1:0]    ext_config_o,
  output logic                               timed_active_o
);
  import pvic_pkg::*;

  localparam int DW = $clog2(NEST_DEPTH + 1);

  typedef struct packed {
    pvic_fsm_t                    st;
    logic [NUM_SRC-1:0]           flags;
    logic [NUM_SRC-1:0]           enables;
    logic [NUM_SRC-1:0][2:0]      prio;
    logic [NUM_TRAP-1:0]          traps;
    logic                         nest_dis;
    logic                         alt_sel;
    logic [EXT_W-1:0]             ext_cfg;
    logic [3:0]                   level;
    logic [NEST_DEPTH-1:0][3:0]   stack;
    logic [DW-1:0]                depth;
    logic [TIMED_DISABLE_W-1:0]            timed_cnt;
    logic                         timed_act;
    logic [3:0]                   pend_level;
    logic [5:0]                   pend_vec;
    logic [31:0]                  rdata;
    logic                         ready;
    logic                         slverr;
    logic                         irq;
    logic                         vec_rd;
    logic [23:0]                  vec_addr;
    logic                         pc_load;
    logic [23:0]                  pc_value;
  } pvic_state_t;

  pvic_state_t q;
  pvic_state_t d;

  // ==========================================================================
  // Helpers

  function automatic logic in_range(input logic [9:0] idx, input logic [11:0] ofs, input int n);
    logic [9:0] base;
    base = ofs[11:2];
    in_range = (idx >= base) && (idx < base + 10'(n));
  endfunction

  function automatic logic in_vec_space(input logic [23:0] a);
    in_vec_space = (a <= VEC_SPACE_END);
  endfunction

  function automatic logic [15:0] reg_rd(input logic [9:0] idx, input pvic_state_t s);
    logic [15:0] w;
    int          r;
    w = 16'h0000;
    if (in_range(idx, OFS_FLAGS, 3)) begin
      r = int'(idx - OFS_FLAGS[11:2]);
      w = s.flags[16*r +: 16];
    end else if (in_range(idx, OFS_ENABLES, 3)) begin
      r = int'(idx - OFS_ENABLES[11:2]);
      w = s.enables[16*r +: 16];
    end else if (in_range(idx, OFS_PRIO, NUM_PRIO)) begin
      r = int'(idx - OFS_PRIO[11:2]);
      for (int n = 0; n < 4; n++) begin
        w[4*n +: 4] = {1'b0, s.prio[4*r+n]};
      end
    end else if (idx == OFS_CTL_TRAP[11:2]) begin
      w[NEST_DIS_BIT]                = s.nest_dis;
      w[TRAP_LSB +: NUM_TRAP]        = s.traps;
    end else if (idx == OFS_CTL_EXT[11:2]) begin
      w[ALT_TABLE_BIT]               = s.alt_sel;
      w[TIMED_DIS_BIT]               = s.timed_act;
      w[EXT_LSB +: EXT_W]            = s.ext_cfg;
    end else if (idx == OFS_CPU_LEVEL[11:2]) begin
      w[3:0]                         = s.level;
    end else if (idx == OFS_STATUS[11:2]) begin
      w[5:0]                         = s.pend_vec;
      w[STAT_DEPTH_LSB +: DW]        = s.depth;
    end
    reg_rd = w;
  endfunction

  // ==========================================================================
  // Arbitration

  logic [NUM_SRC-1:0] eligible;
  logic               src_found;
  logic [5:0]         src_idx;
  logic [2:0]         src_lvl;
  logic               trap_found;
  logic [1:0]         trap_idx;
  logic [3:0]         trap_lvl;
  logic               src_take;
  logic               trap_take;

  always_comb begin
    // A flag only competes when enabled, implemented and at a nonzero level.
    for (int s = 0; s < NUM_SRC; s++) begin
      eligible[s] = q.flags[s] & q.enables[s] & SRC_IMPL_MASK[s] & (q.prio[s] != 3'h0);
    end
    src_found = 1'b0;
    src_idx   = 6'h00;
    src_lvl   = 3'h0;
    // Walking downward with >= lets the lowest number win a tie at the top level.
    for (int s = NUM_SRC - 1; s >= 0; s--) begin
      if (eligible[s] && (q.prio[s] >= src_lvl)) begin
        src_found = 1'b1;
        src_idx   = 6'(s);
        src_lvl   = q.prio[s];
      end
    end
    trap_found = 1'b0;
    trap_idx   = 2'h0;
    for (int k = 0; k < NUM_TRAP; k++) begin
      if (q.traps[k]) begin
        trap_found = 1'b1;
        trap_idx   = 2'(k);
      end
    end
    trap_lvl  = TRAP_LEVEL_BASE + {2'b00, trap_idx};
    trap_take = trap_found && (trap_lvl > q.level);
    src_take  = src_found
              && ({1'b0, src_lvl} > q.level)
              && !(q.nest_dis && (q.depth != '0))
              && !(q.timed_act && (src_lvl <= TIMED_MAX_LEVEL));
  end

  // ==========================================================================
  // Next state

  logic [9:0] idx;
  logic       setup;
  logic       wr_acc;
  logic       mapped;
  logic       addr_err;
  logic [5:0] take_vec;

  always_comb begin
    idx      = paddr_i[11:2];
    setup    = psel_i & ~penable_i;
    mapped   = idx <= OFS_STATUS[11:2];
    wr_acc   = psel_i & penable_i & q.ready & pwrite_i & mapped;
    addr_err = (fetch_valid_i & fetch_normal_i & in_vec_space(fetch_addr_i))
             | (jump_valid_i & in_vec_space(jump_target_i));
    take_vec = trap_take ? TRAP_VEC_BASE + {4'h0, trap_idx} : src_idx + SRC_VEC_OFFSET;
    d        = q;

    // APB: zero wait states, the answer is prepared in the setup cycle.
    d.ready  = setup;
    d.slverr = setup & ~mapped;
    if (setup) begin
      d.rdata = pwrite_i ? 32'h0000_0000 : {16'h0000, reg_rd(idx, q)};
    end

    // Software writes come first so that a same-cycle hardware event wins below.
    if (wr_acc) begin
      for (int r = 0; r < 3; r++) begin
        if (idx == OFS_FLAGS[11:2] + 10'(r)) begin
          d.flags[16*r +: 16] = pwdata_i[15:0] & SRC_IMPL_MASK[16*r +: 16];
        end
        if (idx == OFS_ENABLES[11:2] + 10'(r)) begin
          d.enables[16*r +: 16] = pwdata_i[15:0] & SRC_IMPL_MASK[16*r +: 16];
        end
      end
      for (int r = 0; r < NUM_PRIO; r++) begin
        if (idx == OFS_PRIO[11:2] + 10'(r)) begin
          for (int n = 0; n < 4; n++) begin
            if (4*r + n <= LAST_PRIO_SRC) begin
              d.prio[4*r+n] = pwdata_i[4*n +: 3];
            end
          end
        end
      end
      if (idx == OFS_CTL_TRAP[11:2]) begin
        d.nest_dis = pwdata_i[NEST_DIS_BIT];
        d.traps    = pwdata_i[TRAP_LSB +: NUM_TRAP];
      end
      if (idx == OFS_CTL_EXT[11:2]) begin
        d.alt_sel = pwdata_i[ALT_TABLE_BIT];
        d.ext_cfg = pwdata_i[EXT_LSB +: EXT_W];
      end
      if ((idx == OFS_CPU_LEVEL[11:2]) && !q.nest_dis) begin
        d.level = pwdata_i[3:0];
      end
    end

    // Events set flags regardless of enables; set wins over a clearing write.
    d.flags = d.flags | (src_event_i & SRC_IMPL_MASK);
    d.traps = d.traps | trap_event_i;
    d.traps[TRAP_ADDR_IDX] = d.traps[TRAP_ADDR_IDX] | addr_err;

    // Timed disable counts retired instructions down to zero.
    if (timed_start_i) begin
      d.timed_cnt = timed_count_i;
    end else if (instr_retire_i && (q.timed_cnt != '0)) begin
      d.timed_cnt = q.timed_cnt - TIMED_DISABLE_W'(1);
    end
    d.timed_act = d.timed_cnt != '0;

    unique case (q.st)
      PV_IDLE: begin
        d.pc_load = 1'b0;
        if (return_i && (q.depth != '0)) begin
          d.level = q.stack[q.depth - DW'(1)];
          d.depth = q.depth - DW'(1);
        end else if (trap_take || src_take) begin
          d.st         = PV_FETCH;
          d.irq        = 1'b1;
          d.vec_rd     = 1'b1;
          d.pend_vec   = take_vec;
          d.pend_level = trap_take ? trap_lvl : {1'b0, src_lvl};
          d.vec_addr   = (q.alt_sel ? ALTERNATE_VECTOR_TABLE_BASE : IVT_BASE) + {17'h00000, take_vec, 1'b0};
        end
      end
      PV_FETCH: begin
        if (vec_data_valid_i) begin
          d.st       = PV_LOAD;
          d.vec_rd   = 1'b0;
          d.pc_load  = 1'b1;
          d.pc_value = vec_data_i;
          // A full stack stops pushing, so the level beneath the deepest service is lost on return.
          if (q.depth < DW'(NEST_DEPTH)) begin
            d.stack[q.depth] = q.level;
            d.depth          = q.depth + DW'(1);
          end
          d.level = q.pend_level;
        end
      end
      PV_LOAD: begin
        d.st      = PV_IDLE;
        d.pc_load = 1'b0;
        d.irq     = 1'b0;
      end
      default: begin
        d.st = PV_IDLE;
      end
    endcase
  end

  // ==========================================================================
  // State register

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      q       <= '0;
      q.st    <= PV_IDLE;
      q.level <= RST_CPU_LEVEL;
    end else begin
      q <= d;
    end
  end

  // ==========================================================================
  // Outputs, each straight from the state register

  assign prdata_o       = q.rdata;
  assign pready_o       = q.ready;
  assign pslverr_o      = q.slverr;
  assign irq_o          = q.irq;
  assign vec_rd_o       = q.vec_rd;
  assign vec_addr_o     = q.vec_addr;
  assign pc_load_o      = q.pc_load;
  assign pc_value_o     = q.pc_value;
  assign cpu_level_o    = q.level;
  assign ext_config_o   = q.ext_cfg;
  assign timed_active_o = q.timed_act;

endmodule

// ===== bench/pvic_checker.sv
// Port assertions for the interrupt controller.
// Assumes binding to pvic_top; sees only its ports.
`timescale 1ns/10ps
module pvic_checker #(
  parameter int TIMED_DISABLE_W = 14
) (
  input wire logic              clock_i,
  input wire logic              rst_n_i,
  input wire logic              psel_i,
  input wire logic              penable_i,
  input wire logic              pwrite_i,
  input wire logic [11:0]       paddr_i,
  input wire logic [31:0]       prdata_o,
  input wire logic              pready_o,
  input wire logic              pslverr_o,
  input wire logic              timed_start_i,
  input wire logic [TIMED_DISABLE_W-1:0] timed_count_i,
  input wire logic              return_i,
  input wire logic              vec_data_valid_i,
  input wire logic [23:0]       vec_data_i,
  input wire logic              irq_o,
  input wire logic              vec_rd_o,
  input wire logic [23:0]       vec_addr_o,
  input wire logic              pc_load_o,
  input wire logic [23:0]       pc_value_o,
  input wire logic [3:0]        cpu_level_o,
  input wire logic              timed_active_o
);
  import pvic_pkg::*;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_setup; psel_i && !penable_i; endsequence
  sequence s_wait; vec_rd_o && !vec_data_valid_i; endsequence
  sequence s_take; vec_rd_o && vec_data_valid_i; endsequence
  a_apb_ready: assert property (s_setup |=> pready_o ##1 !pready_o)
    else $error("pready not one cycle after setup");
  a_unmapped_err: assert property (pready_o |-> pslverr_o == (paddr_i[11:2] > 10'h015))
    else $error("pslverr wrong for address");
  a_read_upper: assert property (pready_o && !pwrite_i |-> prdata_o[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  a_vec_hold: assert property (s_wait |=> vec_rd_o && $stable(vec_addr_o))
    else $error("vector read dropped early");
  a_vec_space: assert property (vec_rd_o |-> vec_addr_o >= IVT_BASE && vec_addr_o[23:9] == 15'h0000)
    else $error("vector address outside table");
  a_pc_value: assert property (s_take |=> pc_load_o && !vec_rd_o && pc_value_o == $past(vec_data_i))
    else $error("pc value not the fetched word");
  a_fetch_done: assert property ($rose(irq_o) |-> vec_rd_o ##[1:50] pc_load_o)
    else $error("vector fetch did not complete");
  a_load_pulse: assert property (pc_load_o |=> !pc_load_o && !irq_o)
    else $error("pc load not a single pulse");
  a_level_rise: assert property (pc_load_o && !cpu_level_o[3] |-> cpu_level_o > $past(cpu_level_o))
    else $error("accepted level not above old level");
  a_trap_level: assert property (pc_load_o && $past(vec_addr_o) < IVT_BASE + 24'h000010 |-> cpu_level_o[3])
    else $error("trap serviced without top level bit");
  a_level_cause: assert property ($changed(cpu_level_o) |-> pc_load_o || $past(return_i)
    || ($past(pwrite_i) && $past(penable_i)))
    else $error("cpu level changed without cause");
  a_timed_set: assert property (timed_start_i && timed_count_i != '0 |=> timed_active_o)
    else $error("timed disable flag not set");
endmodule

// ===== bench/pvic_vec_model.sv
// Program memory answering vector reads of the controller.
// Assumes one read outstanding; latency set by lat_i.
`timescale 1ns/10ps
module pvic_vec_model (
  input  wire logic        clock_i,
  input  wire logic [3:0]  lat_i,
  input  wire logic        rd_i,
  input  wire logic [23:0] addr_i,
  output logic             valid_o,
  output logic [23:0]      data_o
);
  int cnt = 0;
  initial begin
    valid_o = 1'b0;
    data_o = 24'h000000;
  end
  // Data toggles when not valid so a late sample cannot look right.
  always @(posedge clock_i) begin
    if (rd_i && !valid_o && cnt == int'(lat_i)) begin
      valid_o <= 1'b1;
      data_o <= addr_i ^ 24'h5A0000;
      cnt <= 0;
    end else begin
      valid_o <= 1'b0;
      data_o <= ~data_o;
      cnt <= (rd_i && !valid_o) ? cnt + 1 : 0;
    end
  end
endmodule

// ===== bench/pvic_top_bench.sv
// Self-checking bench of the interrupt controller.
// Assumes the vector memory model on the fetch side.
`timescale 1ns/10ps
module pvic_top_bench;
  import pvic_pkg::*;
  logic clock_i = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 0, penable = 0, pwrite = 0, f_val = 0, j_val = 0, t_start = 0, retire = 0, ret_p = 0;
  logic f_norm = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, rdat, prdata;
  logic [47:0] src_ev = '0;
  logic [3:0]  trap_ev = '0, lat = '0, level;
  logic [23:0] f_addr = '0, j_tgt = '0, vd, vec_addr, pc_value;
  logic [13:0] t_cnt = '0;
  logic [4:0]  ext_cfg;
  logic rerr, vdv, pready, pslverr, irq, vec_rd, pc_load, t_act;
  int err_count = 0;
  int n_compared = 0;
  initial forever #2 clock_i = ~clock_i;
  pvic_top uut (.clock_i(clock_i), .rst_n_i(rst_n), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .src_event_i(src_ev), .trap_event_i(trap_ev), .fetch_valid_i(f_val),
    .fetch_normal_i(f_norm), .fetch_addr_i(f_addr), .jump_valid_i(j_val), .jump_target_i(j_tgt),
    .timed_start_i(t_start), .timed_count_i(t_cnt), .instr_retire_i(retire), .return_i(ret_p),
    .vec_data_valid_i(vdv), .vec_data_i(vd), .irq_o(irq), .vec_rd_o(vec_rd), .vec_addr_o(vec_addr),
    .pc_load_o(pc_load), .pc_value_o(pc_value), .cpu_level_o(level), .ext_config_o(ext_cfg),
    .timed_active_o(t_act));
  pvic_vec_model mem (.clock_i(clock_i), .lat_i(lat), .rd_i(vec_rd), .addr_i(vec_addr),
    .valid_o(vdv), .data_o(vd));
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic bail;
    err_count++;
    $display("BAD wait exp done got timeout");
    final_report;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  // Request held until pready is seen high; data taken in that cycle.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock_i);
    penable <= 1'b1;
    do begin
      @(posedge clock_i);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) bail;
    @(posedge clock_i);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), e, rdat);
  endtask
  task automatic ev(input logic [47:0] m);
    src_ev <= m;
    @(posedge clock_i);
    src_ev <= '0;
    @(posedge clock_i);
  endtask
  task automatic ret;
    ret_p <= 1'b1;
    @(posedge clock_i);
    ret_p <= 1'b0;
    @(posedge clock_i);
  endtask
  task automatic no_irq(input int c);
    int hits;
    hits = 0;
    repeat (c) begin
      @(negedge clock_i);
      if (irq !== 1'b0) hits++;
    end
    chk("irq", 32'h0, 32'(hits));
    @(posedge clock_i);
  endtask
  task automatic wait_vec(input logic [23:0] ea, input logic [3:0] el);
    logic [23:0] va;
    int n;
    va = '0;
    n = 0;
    while (pc_load !== 1'b1 && n < 200) begin
      @(negedge clock_i);
      if (vec_rd === 1'b1) va = vec_addr;
      n++;
    end
    if (n >= 200) bail;
    chk("vec_addr", 32'(ea), 32'(va));
    chk("pc_value", 32'(ea ^ 24'h5A0000), 32'(pc_value));
    chk("cpu_level", 32'(el), 32'(level));
    chk("vec_rd", 32'h0, 32'(vec_rd));
    @(posedge clock_i);
  endtask
  task automatic t_regs;
    for (int i = 0; i < 22; i++) rd(12'(4 * i), 32'h0);
    wr(OFS_PRIO, 32'h0000FFFF);
    rd(OFS_PRIO, 32'h00007777);
    wr(OFS_PRIO + 12'h02C, 32'h0000FFFF);
    rd(OFS_PRIO + 12'h02C, 32'h00000077);
    wr(OFS_CTL_EXT, 32'h0000001F);
    chk("ext_config", 32'h1F, 32'(ext_cfg));
    rd(12'h058, 32'h0);
    chk("pslverr", 32'h1, 32'(rerr));
    wr(OFS_PRIO + 12'h02C, 32'h0);
    wr(OFS_CTL_EXT, 32'h0);
    $display("t_regs done");
  endtask
  task automatic t_flag;
    wr(OFS_PRIO, 32'h00007000);
    ev(48'h8);
    rd(OFS_FLAGS, 32'h8);
    no_irq(10);
    wr(OFS_FLAGS, 32'h0);
    rd(OFS_FLAGS, 32'h0);
    $display("t_flag done");
  endtask
  task automatic t_arb;
    wr(OFS_PRIO, 32'h00000303);
    wr(OFS_ENABLES, 32'h5);
    lat <= 4'h3;
    ev(48'h5);
    wait_vec(IVT_BASE + 24'h10, 4'h3);
    wr(OFS_FLAGS, 32'h4);
    no_irq(10);
    ret;
    wait_vec(IVT_BASE + 24'h14, 4'h3);
    wr(OFS_FLAGS, 32'h0);
    ret;
    rd(OFS_CPU_LEVEL, 32'h0);
    $display("t_arb done");
  endtask
  task automatic t_dom;
    wr(OFS_PRIO, 32'h1);
    wr(OFS_PRIO + 12'h02C, 32'h5);
    wr(OFS_ENABLES, 32'h3);
    wr(OFS_ENABLES + 12'h008, 32'h1000);
    lat <= 4'h0;
    ev(48'h1000_0000_0003);
    wait_vec(IVT_BASE + 24'h68, 4'h5);
    wr(OFS_FLAGS + 12'h008, 32'h0);
    ret;
    wait_vec(IVT_BASE + 24'h10, 4'h1);
    wr(OFS_FLAGS, 32'h2);
    ret;
    no_irq(10);
    rd(OFS_FLAGS, 32'h2);
    wr(OFS_FLAGS, 32'h0);
    $display("t_dom done");
  endtask
  task automatic t_nest;
    wr(OFS_PRIO, 32'h53);
    wr(OFS_CTL_TRAP, 32'h8000);
    wr(OFS_CPU_LEVEL, 32'h5);
    rd(OFS_CPU_LEVEL, 32'h0);
    ev(48'h1);
    wait_vec(IVT_BASE + 24'h10, 4'h3);
    ev(48'h2);
    no_irq(10);
    wr(OFS_FLAGS, 32'h0);
    ret;
    wr(OFS_CTL_TRAP, 32'h0);
    wr(OFS_CPU_LEVEL, 32'h5);
    rd(OFS_CPU_LEVEL, 32'h5);
    wr(OFS_CPU_LEVEL, 32'h0);
    $display("t_nest done");
  endtask
  task automatic t_timed;
    wr(OFS_PRIO, 32'h76);
    t_cnt <= 14'd20;
    t_start <= 1'b1;
    @(posedge clock_i);
    t_start <= 1'b0;
    rd(OFS_CTL_EXT, 32'h4000);
    chk("timed_active", 32'h1, 32'(t_act));
    ev(48'h1);
    no_irq(10);
    ev(48'h2);
    wait_vec(IVT_BASE + 24'h12, 4'h7);
    wr(OFS_FLAGS, 32'h1);
    ret;
    repeat (20) begin
      retire <= 1'b1;
      @(posedge clock_i);
      retire <= 1'b0;
      @(posedge clock_i);
    end
    wait_vec(IVT_BASE + 24'h10, 4'h6);
    rd(OFS_CTL_EXT, 32'h0);
    chk("timed_active", 32'h0, 32'(t_act));
    wr(OFS_FLAGS, 32'h0);
    ret;
    wr(OFS_ENABLES, 32'h0);
    $display("t_timed done");
  endtask
  // A vector fetch and a jump outside vector space raise nothing; then four trap events,
  // a normal fetch after rollover and a jump into vector space, alternating the two tables.
  task automatic t_trap;
    int idx;
    f_val <= 1'b1;
    f_addr <= 24'h000000;
    j_val <= 1'b1;
    j_tgt <= 24'h000100;
    @(posedge clock_i);
    f_val <= 1'b0;
    j_val <= 1'b0;
    rd(OFS_CTL_TRAP, 32'h0);
    for (int k = 0; k < 6; k++) begin
      idx = (k < 4) ? k : 1;
      wr(OFS_CTL_EXT, 32'(k % 2) << ALT_TABLE_BIT);
      trap_ev <= (k < 4) ? 4'(1 << k) : 4'h0;
      f_val <= (k == 4);
      f_norm <= (k == 4);
      j_val <= (k == 5);
      j_tgt <= 24'h0000FE;
      @(posedge clock_i);
      trap_ev <= '0;
      f_val <= 1'b0;
      f_norm <= 1'b0;
      j_val <= 1'b0;
      wait_vec(((k % 2 == 1) ? ALTERNATE_VECTOR_TABLE_BASE : IVT_BASE) + 24'(2 * (idx + 1)), 4'(11 + idx));
      rd(OFS_CTL_TRAP, 32'(2 << idx));
      wr(OFS_CTL_TRAP, 32'h0);
      ret;
    end
    wr(OFS_CTL_EXT, 32'h0);
    $display("t_trap done");
  endtask
  initial begin
    repeat (10) @(posedge clock_i);
    rst_n <= 1'b1;
    @(posedge clock_i);
    t_regs;
    t_flag;
    t_arb;
    t_dom;
    t_nest;
    t_timed;
    t_trap;
    final_report;
  end
  initial begin
    repeat (60000) @(posedge clock_i);
    bail;
  end
endmodule
bind pvic_top pvic_checker #(.TIMED_DISABLE_W(TIMED_DISABLE_W)) u_chk (.*);
